//--- common/ldac_pkg.sv
package ldac_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register map (byte addresses on the avalon slave)
    localparam logic [3:0] LDAC_ADDR_CONTROL = 4'h0;
    localparam logic [3:0] LDAC_ADDR_LEVEL = 4'h4;
    localparam logic [3:0] LDAC_ADDR_STATUS = 4'h8;

    ////////////////////////////////////////////////////////////////////////////////
    // control register fields
    localparam int LDAC_CTL_ENABLE_BIT = 7;
    localparam int LDAC_CTL_OUT1_BIT = 5;
    localparam int LDAC_CTL_OUT2_BIT = 4;
    localparam int LDAC_CTL_PSS_HI = 3;
    localparam int LDAC_CTL_PSS_LO = 2;
    localparam logic [7:0] LDAC_CTL_WRITE_MASK = 8'hBC;
    localparam logic [7:0] LDAC_CTL_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // level-select register fields
    localparam int LDAC_LEVEL_W = 5;
    localparam int LDAC_LEVELS = 32;
    localparam logic [4:0] LDAC_LEVEL_RESET = 5'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // status register fields
    localparam int LDAC_STS_ENABLE_BIT = 0;
    localparam int LDAC_STS_PIN1_BIT = 1;
    localparam int LDAC_STS_PIN2_BIT = 2;
    localparam int LDAC_STS_RESERVED_BIT = 3;
    localparam int LDAC_STS_SLEEP_BIT = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // positive source codes
    typedef enum logic [1:0]
    {
        LDAC_PSS_SUPPLY = 2'h0,
        LDAC_PSS_EXT_REF = 2'h1,
        LDAC_PSS_FIXED_REF = 2'h2,
        LDAC_PSS_RESERVED = 2'h3
    } ldac_pss_e;

    ////////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed
    {
        logic read;
        logic write;
        logic [3:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } ldac_avs_req_s;

    typedef struct packed
    {
        logic out;
        logic oe;
        logic in_en;
    } ldac_pad_s;

    typedef struct packed
    {
        logic supply;
        logic ext_ref;
        logic fixed_ref;
    } ldac_src_s;

endpackage : ldac_pkg

//--- logic/ldac_control.sv
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ns

module ldac_control
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // avalon-mm slave
    input wire ldac_pkg::ldac_avs_req_s avs_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // port logic drive requests for the two shared pins
    input wire logic port_out1,
    input wire logic port_oe1,
    input wire logic port_out2,
    input wire logic port_oe2,
    // raw pin levels, asynchronous
    input wire logic pin1_in,
    input wire logic pin2_in,
    // pad controls and port read values
    output ldac_pkg::ldac_pad_s pad1,
    output ldac_pkg::ldac_pad_s pad2,
    output logic port_rd1,
    output logic port_rd2,
    // analog switch controls
    output logic conv_on,
    output logic [ldac_pkg::LDAC_LEVELS-1:0] ladder_tap,
    output ldac_pkg::ldac_src_s ladder_src,
    output logic ref_out_pin1,
    output logic ref_out_pin2,
    // internal consumers of the level
    input wire logic cmp_sel_level,
    input wire logic adc_sel_level,
    output logic cmp_pos_connect,
    output logic adc_ch_connect,
    // power state
    input wire logic sleep_active
);
    import ldac_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] ctl_r;
    logic [7:0] ctl_nxt;
    logic [LDAC_LEVEL_W-1:0] level_r;
    logic [LDAC_LEVEL_W-1:0] level_nxt;
    logic wait_r;
    logic [31:0] rdata_r;
    logic pin1_meta_r;
    logic pin1_sync_r;
    logic pin2_meta_r;
    logic pin2_sync_r;
    ldac_pad_s pad1_r;
    ldac_pad_s pad2_r;
    logic port_rd1_r;
    logic port_rd2_r;
    logic conv_on_r;
    ldac_src_s src_r;
    logic out1_r;
    logic out2_r;
    logic cmp_r;
    logic adc_r;

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode
    wire logic req;
    wire logic take;
    wire logic hit_ctl;
    wire logic hit_level;
    wire logic hit_status;
    wire logic wr_ctl;
    wire logic wr_level;
    wire logic [7:0] level_view;
    wire logic [7:0] status_view;
    wire logic [31:0] rd_mux;

    assign req = avs_req.read || avs_req.write;
    // the request completes on the edge that sees waitrequest low
    assign take = req && !wait_r;
    assign hit_ctl = avs_req.address == LDAC_ADDR_CONTROL;
    assign hit_level = avs_req.address == LDAC_ADDR_LEVEL;
    assign hit_status = avs_req.address == LDAC_ADDR_STATUS;
    assign wr_ctl = take && avs_req.write && hit_ctl && avs_req.byteenable[0];
    assign wr_level = take && avs_req.write && hit_level && avs_req.byteenable[0];

    ////////////////////////////////////////////////////////////////////////////////
    // register next values
    // only the implemented bits take a write; the rest stay zero
    assign ctl_nxt = wr_ctl ? (avs_req.writedata[7:0] & LDAC_CTL_WRITE_MASK) : ctl_r;
    assign level_nxt = wr_level ? avs_req.writedata[LDAC_LEVEL_W-1:0] : level_r;

    // sleep entry and wake do not touch the control register, so the converter
    // keeps running asleep unless software turned it off first
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            ctl_r <= LDAC_CTL_RESET;
            level_r <= LDAC_LEVEL_RESET;
        end
        else
        begin
            ctl_r <= ctl_nxt;
            level_r <= level_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // field views
    wire logic en_bit;
    wire logic oe1_bit;
    wire logic oe2_bit;
    wire logic [1:0] pss_bits;

    assign en_bit = ctl_r[LDAC_CTL_ENABLE_BIT];
    assign oe1_bit = ctl_r[LDAC_CTL_OUT1_BIT];
    assign oe2_bit = ctl_r[LDAC_CTL_OUT2_BIT];
    assign pss_bits = ctl_r[LDAC_CTL_PSS_HI:LDAC_CTL_PSS_LO];

    assign level_view = {3'h0, level_r};
    assign status_view = {3'h0, sleep_active, pss_bits == LDAC_PSS_RESERVED,
                          out2_r, out1_r, conv_on_r};

    assign rd_mux = hit_ctl ? {24'h000000, ctl_r} :
                    hit_level ? {24'h000000, level_view} :
                    hit_status ? {24'h000000, status_view} :
                    32'h00000000;

    ////////////////////////////////////////////////////////////////////////////////
    // avalon handshake: one wait cycle, then the answer
    // unmapped addresses read zero and ignore writes
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            wait_r <= 1'b1;
            rdata_r <= 32'h00000000;
        end
        else
        begin
            wait_r <= !(req && wait_r);
            if (req && wait_r && avs_req.read)
                rdata_r <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: second stage is the only reader of the first
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            pin1_meta_r <= 1'b0;
            pin1_sync_r <= 1'b0;
            pin2_meta_r <= 1'b0;
            pin2_sync_r <= 1'b0;
        end
        else
        begin
            pin1_meta_r <= pin1_in;
            pin1_sync_r <= pin1_meta_r;
            pin2_meta_r <= pin2_in;
            pin2_sync_r <= pin2_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // analog routing
    wire ldac_src_s src_nxt;
    wire logic out1_nxt;
    wire logic out2_nxt;

    // reserved code opens every source switch rather than guess a reference
    assign src_nxt.supply = pss_bits == LDAC_PSS_SUPPLY;
    assign src_nxt.ext_ref = pss_bits == LDAC_PSS_EXT_REF;
    assign src_nxt.fixed_ref = pss_bits == LDAC_PSS_FIXED_REF;
    assign out1_nxt = oe1_bit;
    assign out2_nxt = oe2_bit;

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            conv_on_r <= 1'b0;
            src_r <= '0;
            out1_r <= 1'b0;
            out2_r <= 1'b0;
            cmp_r <= 1'b0;
            adc_r <= 1'b0;
        end
        else
        begin
            conv_on_r <= en_bit;
            src_r <= src_nxt;
            out1_r <= out1_nxt;
            out2_r <= out2_nxt;
            // the internal taps follow the converter; an off converter feeds nothing
            cmp_r <= cmp_sel_level && en_bit;
            adc_r <= adc_sel_level && en_bit;
        end
    end

    ldac_tap_decode u_tap
    (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .enable(en_bit),
        .level(level_r),
        .tap_r(ladder_tap)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // pad override: analog output wins over the port logic
    wire ldac_pad_s pad1_nxt;
    wire ldac_pad_s pad2_nxt;

    assign pad1_nxt.out = oe1_bit ? 1'b0 : port_out1;
    assign pad1_nxt.oe = oe1_bit ? 1'b0 : port_oe1;
    assign pad1_nxt.in_en = !oe1_bit;
    assign pad2_nxt.out = oe2_bit ? 1'b0 : port_out2;
    assign pad2_nxt.oe = oe2_bit ? 1'b0 : port_oe2;
    assign pad2_nxt.in_en = !oe2_bit;

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            pad1_r <= '0;
            pad2_r <= '0;
            port_rd1_r <= 1'b0;
            port_rd2_r <= 1'b0;
        end
        else
        begin
            pad1_r <= pad1_nxt;
            pad2_r <= pad2_nxt;
            port_rd1_r <= pin1_sync_r && !oe1_bit;
            port_rd2_r <= pin2_sync_r && !oe2_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign pad1 = pad1_r;
    assign pad2 = pad2_r;
    assign port_rd1 = port_rd1_r;
    assign port_rd2 = port_rd2_r;
    assign conv_on = conv_on_r;
    assign ladder_src = src_r;
    assign ref_out_pin1 = out1_r;
    assign ref_out_pin2 = out2_r;
    assign cmp_pos_connect = cmp_r;
    assign adc_ch_connect = adc_r;

endmodule : ldac_control

//--- logic/ldac_tap_decode.sv
`timescale 1ns/1ns

module ldac_tap_decode
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // level request
    input wire logic enable,
    input wire logic [ldac_pkg::LDAC_LEVEL_W-1:0] level,
    // ladder tap switches, one-hot while enabled, all clear while off
    output logic [ldac_pkg::LDAC_LEVELS-1:0] tap_r
);
    import ldac_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // one switch per ladder tap; all open while the converter is off
    genvar gi;
    generate
        for (gi = 0; gi < LDAC_LEVELS; gi = gi + 1)
        begin : g_tap
            wire logic hit;
            assign hit = enable && (level == LDAC_LEVEL_W'(gi));
            always_ff @(posedge clk_sys)
            begin
                if (!reset_n)
                    tap_r[gi] <= 1'b0;
                else
                    tap_r[gi] <= hit;
            end
        end
    endgenerate

endmodule : ldac_tap_decode

//--- testbench/ldac_control_properties.sv
`timescale 1ns/1ns

module ldac_props
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // watched ports
    input wire ldac_pkg::ldac_avs_req_s avs_req,
    input wire logic avs_waitrequest,
    input wire ldac_pkg::ldac_pad_s pad1,
    input wire logic port_rd1,
    input wire logic conv_on,
    input wire logic [ldac_pkg::LDAC_LEVELS-1:0] ladder_tap,
    input wire ldac_pkg::ldac_src_s ladder_src,
    input wire logic ref_out_pin1,
    input wire logic ref_out_pin2,
    input wire logic cmp_sel_level,
    input wire logic cmp_pos_connect,
    input wire logic sleep_active
);
    import ldac_pkg::*;

    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////
    sequence s_ctl_wr;
        avs_req.write && !avs_waitrequest && avs_req.address == LDAC_ADDR_CONTROL
            && avs_req.byteenable[0];
    endsequence
    // select and converter both quiet long enough for any register stage
    sequence s_calm;
        ($stable(cmp_sel_level) && $stable(conv_on)) [*3];
    endsequence

    property p_enable;
        s_ctl_wr |-> ##2 conv_on == $past(avs_req.writedata[LDAC_CTL_ENABLE_BIT], 2);
    endproperty
    property p_pins;
        s_ctl_wr |-> ##2 {ref_out_pin1, ref_out_pin2} == $past(avs_req.writedata[5:4], 2);
    endproperty
    property p_tap;
        $stable(conv_on) && conv_on == $past(conv_on, 2)
            |-> (conv_on ? $onehot(ladder_tap) : ladder_tap == '0);
    endproperty
    property p_src;
        s_ctl_wr |-> ##2 ladder_src == {$past(avs_req.writedata[3:2], 2) == 2'h0,
            $past(avs_req.writedata[3:2], 2) == 2'h1, $past(avs_req.writedata[3:2], 2) == 2'h2};
    endproperty
    property p_pad;
        ref_out_pin1 |-> !pad1.oe && !pad1.in_en && !pad1.out;
    endproperty
    property p_rd;
        ref_out_pin1 && $past(ref_out_pin1, 2) |-> !port_rd1;
    endproperty
    property p_wake;
        $fell(sleep_active) && !avs_req.write && !$past(avs_req.write)
            |=> $stable(conv_on) && $stable(ref_out_pin1);
    endproperty
    property p_cmp;
        s_calm |-> cmp_pos_connect == (cmp_sel_level && conv_on);
    endproperty
    // reset itself is the cause here, so this one is not disabled by it
    property p_reset;
        disable iff (1'b0)
        !reset_n |=> !conv_on && !ref_out_pin1 && !ref_out_pin2 && ladder_tap == '0;
    endproperty

    a_enable: assert property (p_enable)
        else $error("converter power does not follow bit 7");
    a_pins: assert property (p_pins)
        else $error("output pin switches do not follow bits 5 and 4");
    a_tap: assert property (p_tap)
        else $error("ladder tap is not one-hot while on or not clear while off");
    a_src: assert property (p_src)
        else $error("positive source select decoded wrongly");
    a_pad: assert property (p_pad)
        else $error("digital pad still active on a converter pin");
    a_rd: assert property (p_rd)
        else $error("port read not zero on a converter pin");
    a_wake: assert property (p_wake)
        else $error("converter state changed on wake");
    a_cmp: assert property (p_cmp)
        else $error("comparator connection not gated by converter power");
    a_reset: assert property (p_reset)
        else $error("reset did not clear converter outputs");

endmodule : ldac_props

//--- testbench/tb_top.sv
`timescale 1ns/1ns

module tb_top;
    import ldac_pkg::*;

    logic clk_sys = 1'b0;
    logic reset_n;
    ldac_avs_req_s req;
    logic [31:0] rdata;
    logic wreq;
    logic oe1, out1, oe2, out2, pin1, pin2, sel, asel, slp;
    ldac_pad_s pad1, pad2;
    logic rd1, rd2, con, rp1, rp2, cmpc, adcc;
    logic [LDAC_LEVELS-1:0] tap;
    ldac_src_s src;
    logic [31:0] v;
    int miscompares = 0;
    int cmp_count = 0;

    ldac_control DUT (.clk_sys, .reset_n, .avs_req(req), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .port_out1(out1), .port_oe1(oe1), .port_out2(out2),
        .port_oe2(oe2), .pin1_in(pin1), .pin2_in(pin2), .pad1, .pad2,
        .port_rd1(rd1), .port_rd2(rd2), .conv_on(con), .ladder_tap(tap),
        .ladder_src(src), .ref_out_pin1(rp1), .ref_out_pin2(rp2), .cmp_sel_level(sel),
        .adc_sel_level(asel), .cmp_pos_connect(cmpc), .adc_ch_connect(adcc),
        .sleep_active(slp));

    always #5 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////
    task cmp(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask : cmp

    // one avalon cycle; an extra edge at the end keeps two requests apart
    task acc(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        req <= '{read: !w, write: w, address: a, byteenable: be, writedata: d};
        @(posedge clk_sys);
        // only the watchdog ends a wait that never sees the answer
        while (wreq !== 1'b0)
            @(posedge clk_sys);
        v = rdata;
        req <= '0;
        @(posedge clk_sys);
    endtask : acc

    task wr(input logic [3:0] a, input logic [31:0] d);
        acc(1'b1, a, d, 4'hF);
    endtask : wr

    task chk_rd(input logic [3:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0, 4'hF);
        cmp(v, e);
    endtask : chk_rd

    task wait_n(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : wait_n

    task results;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    initial
    begin
        wait_n(3000);
        miscompares++;
        results;
    end

    initial
    begin
        reset_n <= 1'b0;
        req <= '0;
        {oe1, out1, oe2, out2, pin1, pin2, sel, asel, slp} <= 9'h1DC;
        wait_n(4);
        reset_n <= 1'b1;
        wait_n(1);
        chk_rd(LDAC_ADDR_CONTROL, 32'h0);
        chk_rd(LDAC_ADDR_LEVEL, 32'h0);
        cmp(32'({pad1, pad2, rd1, rd2}), 32'hEF);
        wr(LDAC_ADDR_CONTROL, 32'hFFFFFFFF);
        wait_n(5);
        chk_rd(LDAC_ADDR_CONTROL, 32'hBC);
        cmp(32'({con, rp1, rp2, pad1, rd1, cmpc}), 32'hE1);
        cmp(32'({pad2, rd2, adcc}), 32'h0);
        wr(LDAC_ADDR_CONTROL, 32'h90);
        wait_n(5);
        cmp(32'({rp1, rp2, pad1, rd1, rd2}), 32'h3E);
        cmp(32'(pad2), 32'h0);
        // swap the two consumer selects to show each connect follows its own
        sel <= 1'b0;
        asel <= 1'b1;
        wait_n(3);
        cmp(32'({cmpc, adcc}), 32'h1);
        for (int i = 0; i < LDAC_LEVELS; i++)
        begin
            wr(LDAC_ADDR_LEVEL, 32'hE0 | i);
            wait_n(3);
            cmp(tap, 32'h1 << i);
        end
        chk_rd(LDAC_ADDR_LEVEL, 32'h1F);
        for (int k = 0; k < 4; k++)
        begin
            wr(LDAC_ADDR_CONTROL, 32'h80 | (k << 2));
            wait_n(3);
            cmp(32'(src), 32'({k == 0, k == 1, k == 2}));
            chk_rd(LDAC_ADDR_STATUS, (k == 3) ? 32'h9 : 32'h1);
        end
        // a partial-byte write and an unmapped write must both leave no trace
        acc(1'b1, LDAC_ADDR_CONTROL, 32'h0, 4'hE);
        wr(4'hC, 32'hFF);
        chk_rd(4'hC, 32'h0);
        chk_rd(LDAC_ADDR_CONTROL, 32'h8C);
        wr(LDAC_ADDR_CONTROL, 32'h0);
        wait_n(3);
        cmp(tap, 32'h0);
        cmp(32'({con, cmpc, adcc}), 32'h0);
        // converter deliberately left on across sleep: nothing forces it off
        wr(LDAC_ADDR_CONTROL, 32'hA4);
        slp <= 1'b1;
        wait_n(3);
        chk_rd(LDAC_ADDR_STATUS, 32'h13);
        slp <= 1'b0;
        wait_n(3);
        cmp(32'({con, rp1}), 32'h3);
        chk_rd(LDAC_ADDR_CONTROL, 32'hA4);
        wr(LDAC_ADDR_LEVEL, 32'h15);
        reset_n <= 1'b0;
        wait_n(4);
        reset_n <= 1'b1;
        wait_n(1);
        cmp(tap, 32'h0);
        cmp(32'({con, rp1, rp2}), 32'h0);
        chk_rd(LDAC_ADDR_LEVEL, 32'h0);
        chk_rd(LDAC_ADDR_CONTROL, 32'h0);
        results;
    end

endmodule : tb_top

bind ldac_control ldac_props u_props (.clk_sys, .reset_n, .avs_req, .avs_waitrequest,
    .pad1, .port_rd1, .conv_on, .ladder_tap, .ladder_src, .ref_out_pin1, .ref_out_pin2,
    .cmp_sel_level, .cmp_pos_connect, .sleep_active);
